// ### common/mvc_pkg.sv
// package for the interrupt-message / product-data / vendor capability register bank
// assumes a single 20 MHz core clock and an Avalon-MM register slave
package mvc_pkg;

    // ------------------------------------------------------------------
    // register byte offsets
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_MSG_CTRL  = 8'h4c;
    localparam logic [7:0] OFS_MSG_ADDR  = 8'h50;
    localparam logic [7:0] OFS_MSG_UADDR = 8'h54;
    localparam logic [7:0] OFS_MSG_DATA  = 8'h58;
    localparam logic [7:0] OFS_PD_CTRL   = 8'h5c;
    localparam logic [7:0] OFS_PD_WORD   = 8'h60;
    localparam logic [7:0] OFS_VEND_HDR  = 8'h64;
    localparam logic [7:0] OFS_IRQ_STAT  = 8'h80;
    localparam logic [7:0] OFS_IRQ_MASK  = 8'h84;

    // ------------------------------------------------------------------
    // fixed header values and field positions
    // ------------------------------------------------------------------
    localparam logic [7:0]  MSG_CAP_ID    = 8'h05;
    localparam logic [7:0]  MSG_NEXT_PTR  = 8'h64;
    localparam logic [7:0]  PD_CAP_ID     = 8'h03;
    localparam logic [7:0]  PD_NEXT_PTR   = 8'h64;
    localparam logic [7:0]  VEND_CAP_ID   = 8'h09;
    localparam logic [7:0]  VEND_NEXT_PTR = 8'hb0;
    localparam logic [15:0] VEND_LENGTH   = 16'h0034;
    localparam int          MSG_EN_BIT    = 16;
    localparam int          MSG_64_BIT    = 23;
    localparam int          PD_ADDR_LSB   = 18;
    localparam int          PD_WREN_BIT   = 30;
    localparam int          PD_FLAG_BIT   = 31;
    localparam logic [31:0] RST_ZERO      = 32'h0000_0000;

    // interrupt status bits
    localparam int IRQ_PD_DONE = 0;
    localparam int IRQ_MSG_REQ = 1;
    localparam int IRQ_W       = 2;

    // ------------------------------------------------------------------
    // eeprom access sequencer states
    // ------------------------------------------------------------------
    typedef enum logic [2:0] {
        MVC_IDLE = 3'b001,
        MVC_RD   = 3'b010,
        MVC_WR   = 3'b100
    } mvc_state_t;

    // eeprom side request group
    typedef struct packed {
        logic        req;
        logic        we;
        logic [5:0]  addr;
        logic [31:0] wdata;
    } mvc_rom_req_t;

    // outgoing interrupt message write
    typedef struct packed {
        logic        valid;
        logic [63:0] addr;
        logic [15:0] data;
    } mvc_msg_t;

    // whole block state
    typedef struct packed {
        mvc_state_t   st;
        logic         msg_en;
        logic [2:0]   msg_multi;
        logic [29:0]  msg_addr;
        logic [31:0]  msg_uaddr;
        logic [15:0]  msg_data;
        logic [5:0]   pd_addr;
        logic         pd_wren;
        logic         pd_flag;
        logic [31:0]  pd_word;
        logic [IRQ_W-1:0] irq_stat;
        logic [IRQ_W-1:0] irq_mask;
        logic [31:0]  rdata;
        logic         ack;
        mvc_rom_req_t rom;
        mvc_msg_t     msg;
        logic         intx;
        logic         svc_pend;
    } mvc_regs_t;

endpackage

// ### logic/mvc_cap_regs.sv
// capability register bank: interrupt message, product data, vendor header
// assumes an Avalon-MM master on the core clock and an eeprom engine that
// answers a held request with a one-cycle done pulse
//
// The Avalon-MM register port was decided locally.
`timescale 1ns/1ps

module mvc_cap_regs #(
    parameter bit IS_DOWNSTREAM = 1'b1
) (
    input  wire logic                 i_core_clk,
    input  wire logic                 i_rstn,
    // avalon-mm register slave
    input  wire logic [7:0]           i_address,
    input  wire logic                 i_read,
    input  wire logic                 i_write,
    input  wire logic [31:0]          i_writedata,
    input  wire logic [3:0]           i_byteenable,
    output logic      [31:0]          o_readdata,
    output logic                      o_waitrequest,
    // eeprom engine
    output mvc_pkg::mvc_rom_req_t     o_rom,
    input  wire logic                 i_rom_done,
    input  wire logic [31:0]          i_rom_rdata,
    // service request from the port's own logic
    input  wire logic                 i_svc_req,
    input  wire logic                 i_msg_ready,
    output mvc_pkg::mvc_msg_t         o_msg,
    output logic                      o_intx,
    output logic                      o_irq
);

    mvc_pkg::mvc_regs_t r;
    mvc_pkg::mvc_regs_t next_r;

    // ------------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------------
    // byte-lane merge used by every writable register
    function automatic logic [31:0] be_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
        logic [31:0] res;
        res = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                res[i*8 +: 8] = wd[i*8 +: 8];
            end
        end
        return res;
    endfunction

    // capability presence per port role
    logic msg_present;
    logic pd_present;
    assign msg_present = IS_DOWNSTREAM;
    assign pd_present  = !IS_DOWNSTREAM;

    logic        acc;
    logic [31:0] cur;
    logic [31:0] wv;
    assign acc = (i_read || i_write) && !r.ack;

    // current word image of the addressed register
    always_comb begin
        cur = mvc_pkg::RST_ZERO;
        case (i_address)
            mvc_pkg::OFS_MSG_CTRL: begin
                if (msg_present) begin
                    cur[7:0]  = mvc_pkg::MSG_CAP_ID;
                    cur[15:8] = mvc_pkg::MSG_NEXT_PTR;
                    cur[mvc_pkg::MSG_EN_BIT] = r.msg_en;
                    cur[22:20] = r.msg_multi;
                    cur[mvc_pkg::MSG_64_BIT] = 1'b1;
                end
            end
            mvc_pkg::OFS_MSG_ADDR:  if (msg_present) cur = {r.msg_addr, 2'b00};
            mvc_pkg::OFS_MSG_UADDR: if (msg_present) cur = r.msg_uaddr;
            mvc_pkg::OFS_MSG_DATA:  if (msg_present) cur = {16'h0000, r.msg_data};
            mvc_pkg::OFS_PD_CTRL: begin
                if (pd_present) begin
                    cur[7:0]  = mvc_pkg::PD_CAP_ID;
                    cur[15:8] = mvc_pkg::PD_NEXT_PTR;
                    cur[mvc_pkg::PD_ADDR_LSB +: 6] = r.pd_addr;
                    cur[mvc_pkg::PD_WREN_BIT] = r.pd_wren;
                    cur[mvc_pkg::PD_FLAG_BIT] = r.pd_flag;
                end
            end
            mvc_pkg::OFS_PD_WORD:  if (pd_present) cur = r.pd_word;
            mvc_pkg::OFS_VEND_HDR: cur = {mvc_pkg::VEND_LENGTH, mvc_pkg::VEND_NEXT_PTR,
                                          mvc_pkg::VEND_CAP_ID};
            mvc_pkg::OFS_IRQ_STAT: cur = {30'h0000_0000, r.irq_stat};
            mvc_pkg::OFS_IRQ_MASK: cur = {30'h0000_0000, r.irq_mask};
            default:               cur = mvc_pkg::RST_ZERO;
        endcase
    end

    assign wv = be_merge(cur, i_writedata, i_byteenable);

    // ------------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        next_r     = r;
        next_r.ack = acc;                 // one wait cycle, then the answer
        if (acc && i_read) begin
            next_r.rdata = cur;
        end

        // register writes
        if (acc && i_write) begin
            case (i_address)
                mvc_pkg::OFS_MSG_CTRL: begin
                    if (msg_present) begin
                        next_r.msg_en    = wv[mvc_pkg::MSG_EN_BIT];
                        next_r.msg_multi = wv[22:20];
                    end
                end
                mvc_pkg::OFS_MSG_ADDR:  if (msg_present) next_r.msg_addr  = wv[31:2];
                mvc_pkg::OFS_MSG_UADDR: if (msg_present) next_r.msg_uaddr = wv;
                mvc_pkg::OFS_MSG_DATA:  if (msg_present) next_r.msg_data  = wv[15:0];
                mvc_pkg::OFS_PD_CTRL: begin
                    // a new command is ignored while a cycle is in flight
                    if (pd_present && r.st == mvc_pkg::MVC_IDLE && i_byteenable[3]) begin
                        next_r.pd_addr = wv[mvc_pkg::PD_ADDR_LSB +: 6];
                        next_r.pd_wren = wv[mvc_pkg::PD_WREN_BIT];
                        next_r.pd_flag = wv[mvc_pkg::PD_FLAG_BIT];
                        if (!wv[mvc_pkg::PD_FLAG_BIT]) begin
                            next_r.st = mvc_pkg::MVC_RD;
                        end else if (wv[mvc_pkg::PD_WREN_BIT]) begin
                            next_r.st = mvc_pkg::MVC_WR;
                        end
                    end
                end
                mvc_pkg::OFS_PD_WORD:  if (pd_present) next_r.pd_word = wv;
                mvc_pkg::OFS_IRQ_MASK: next_r.irq_mask = wv[mvc_pkg::IRQ_W-1:0];
                default: ;
            endcase
        end

        // read of the status register clears it
        if (acc && i_read && i_address == mvc_pkg::OFS_IRQ_STAT) begin
            next_r.irq_stat = '0;
        end

        // eeprom sequencer
        next_r.rom.req   = 1'b0;
        next_r.rom.we    = 1'b0;
        next_r.rom.addr  = next_r.pd_addr;
        next_r.rom.wdata = next_r.pd_word;
        case (next_r.st)
            mvc_pkg::MVC_IDLE: ;
            mvc_pkg::MVC_RD: next_r.rom.req = 1'b1;
            mvc_pkg::MVC_WR: begin
                next_r.rom.req = 1'b1;
                next_r.rom.we  = 1'b1;
            end
            default: next_r.st = mvc_pkg::MVC_IDLE;
        endcase
        if (r.st != mvc_pkg::MVC_IDLE && i_rom_done) begin
            next_r.st      = mvc_pkg::MVC_IDLE;
            next_r.rom.req = 1'b0;
            next_r.rom.we  = 1'b0;
            if (r.st == mvc_pkg::MVC_RD) begin
                next_r.pd_word = i_rom_rdata;
                next_r.pd_flag = 1'b1;
            end else begin
                next_r.pd_flag = 1'b0;
            end
            next_r.irq_stat[mvc_pkg::IRQ_PD_DONE] = 1'b1;   // set wins over read-clear
        end

        // service requests, downstream role only: message write when enabled, legacy wire otherwise
        if (i_svc_req) begin
            next_r.svc_pend = 1'b1;
        end
        if (r.msg.valid && i_msg_ready) begin
            next_r.msg.valid = 1'b0;
            next_r.irq_stat[mvc_pkg::IRQ_MSG_REQ] = 1'b1;
        end
        next_r.intx = 1'b0;
        if (!msg_present) begin
            next_r.svc_pend = 1'b0;
        end else if (r.msg_en) begin
            if (r.svc_pend && !r.msg.valid) begin
                next_r.svc_pend   = i_svc_req;
                next_r.msg.valid  = 1'b1;
                next_r.msg.addr   = {r.msg_uaddr, r.msg_addr, 2'b00};
                next_r.msg.data   = r.msg_data;
            end
        end else begin
            next_r.intx      = r.svc_pend || i_svc_req;
            next_r.svc_pend  = 1'b0;
            next_r.msg.valid = 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn) begin
            r          <= '0;
            r.st       <= mvc_pkg::MVC_IDLE;
            r.msg_addr <= 30'h0000_0000;
        end else begin
            r <= next_r;
        end
    end

    // outputs
    assign o_readdata    = r.rdata;
    assign o_waitrequest = !r.ack;
    assign o_rom         = r.rom;
    assign o_msg         = r.msg;
    assign o_intx        = r.intx;
    assign o_irq         = |(r.irq_stat & r.irq_mask);

endmodule

// ### testbench/mvc_cap_regs_monitor.sv
// checker for the capability register bank, bound to every instance
// sees only the top module's ports and its role parameter
`timescale 1ns/1ps
module mvc_cap_regs_monitor #(
    parameter bit IS_DOWNSTREAM = 1'b1
) (
    input wire logic                  i_core_clk,
    input wire logic                  i_rstn,
    input wire logic [7:0]            i_address,
    input wire logic                  i_read,
    input wire logic                  i_write,
    input wire logic [31:0]           i_writedata,
    input wire logic [3:0]            i_byteenable,
    input wire logic [31:0]           o_readdata,
    input wire logic                  o_waitrequest,
    input wire mvc_pkg::mvc_rom_req_t o_rom,
    input wire logic                  i_rom_done,
    input wire logic [31:0]           i_rom_rdata,
    input wire logic                  i_svc_req,
    input wire logic                  i_msg_ready,
    input wire mvc_pkg::mvc_msg_t     o_msg,
    input wire logic                  o_intx,
    input wire logic                  o_irq
);
    default clocking @(posedge i_core_clk); endclocking
    default disable iff (!i_rstn);
    logic en_q;
    // mirror of the message enable, updated at the edge that ends the write, one edge after the bank takes it
    always_ff @(posedge i_core_clk) begin
        if (!i_rstn)
            en_q <= 1'b0;
        else if (i_write && !o_waitrequest && i_address == 8'h4c && i_byteenable[2])
            en_q <= i_writedata[16];
    end
    a_access_answer: assert property ((i_read || i_write) && o_waitrequest |=> !o_waitrequest)
        else $error("access not answered one cycle after it was taken");
    a_answer_single: assert property (!o_waitrequest |=> o_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_msg_align: assert property (o_msg.valid |-> o_msg.addr[1:0] == 2'b00)
        else $error("message write address not dword aligned");
    a_msg_hold: assert property (o_msg.valid && !i_msg_ready |=> o_msg.valid && $stable(o_msg))
        else $error("message write changed before acceptance");
    a_legacy_on: assert property (IS_DOWNSTREAM && i_svc_req && !en_q |=> o_intx)
        else $error("legacy interrupt missing with message enable clear");
    a_legacy_off: assert property (i_svc_req && en_q |=> !o_intx)
        else $error("legacy interrupt raised with message enable set");
    a_msg_sent: assert property (IS_DOWNSTREAM && i_svc_req && en_q |-> ##[2:40] o_msg.valid)
        else $error("no message write after a service request");
    a_role_split: assert property (IS_DOWNSTREAM ? !o_rom.req : !o_msg.valid)
        else $error("capability active on the wrong port role");
    a_rom_hold: assert property (o_rom.req && !i_rom_done |=> o_rom.req && $stable(o_rom))
        else $error("eeprom request changed before done");
    a_rom_release: assert property (o_rom.req && i_rom_done |=> !o_rom.req)
        else $error("eeprom request held after done");
    c_rom_read: cover property (o_rom.req && !o_rom.we && i_rom_done);
    c_rom_write: cover property (o_rom.req && o_rom.we && i_rom_done);
    c_msg_taken: cover property (o_msg.valid && i_msg_ready);
endmodule

bind mvc_cap_regs mvc_cap_regs_monitor #(.IS_DOWNSTREAM(IS_DOWNSTREAM)) mon_u (.i_core_clk(i_core_clk),
    .i_rstn(i_rstn), .i_address(i_address), .i_read(i_read), .i_write(i_write), .i_writedata(i_writedata),
    .i_byteenable(i_byteenable), .o_readdata(o_readdata), .o_waitrequest(o_waitrequest), .o_rom(o_rom),
    .i_rom_done(i_rom_done), .i_rom_rdata(i_rom_rdata), .i_svc_req(i_svc_req), .i_msg_ready(i_msg_ready),
    .o_msg(o_msg), .o_intx(o_intx), .o_irq(o_irq));

// ### testbench/mvc_rom_model.sv
// eeprom engine and message consumer beyond one port of the bank
// assumes the bank holds its eeprom request until the done pulse
`timescale 1ns/1ps
module mvc_rom_model (
    input wire logic                  i_core_clk,
    input wire mvc_pkg::mvc_rom_req_t i_rom,
    output logic                      o_rom_done,
    output logic [31:0]               o_rom_rdata,
    output logic                      o_msg_ready
);
    logic [31:0] mem [64];
    int          wait_cnt = 0;
    initial begin
        o_rom_done  = 1'b0;
        o_rom_rdata = 32'h0000_0000;
        o_msg_ready = 1'b0;
    end
    // answers after one to six cycles; idle data toggles so a stale word never looks valid
    always @(posedge i_core_clk) begin
        o_rom_done  <= 1'b0;
        o_rom_rdata <= ~o_rom_rdata;
        o_msg_ready <= ($urandom() % 4) != 0;
        if (i_rom.req && !o_rom_done && wait_cnt == 0)
            wait_cnt <= 1 + ($urandom() % 6);
        else if (wait_cnt == 1) begin
            o_rom_done <= 1'b1;
            wait_cnt   <= 0;
            if (i_rom.we)
                mem[i_rom.addr] <= i_rom.wdata;
            else
                o_rom_rdata <= mem[i_rom.addr];
        end else if (wait_cnt > 1)
            wait_cnt <= wait_cnt - 1;
    end
endmodule

// ### testbench/mvc_cap_regs_tb_top.sv
// bench: port 0 is the upstream role, port 1 a downstream role
// assumes the partner model per port and the bound checker
`timescale 1ns/1ps
module mvc_cap_regs_tb_top;
    logic                  core_clk = 1'b0;
    logic                  rstn = 1'b0;
    logic [7:0]            adr [2] = '{2{8'h00}};
    logic                  rd [2] = '{2{1'b0}};
    logic                  wr [2] = '{2{1'b0}};
    logic                  svc [2] = '{2{1'b0}};
    logic [31:0]           wd [2] = '{2{32'h0000_0000}};
    logic                  wreq [2], done [2], rdy [2], intx [2], irq [2];
    logic [31:0]           rdat [2], rrd [2], vals [3];
    mvc_pkg::mvc_rom_req_t rom [2];
    mvc_pkg::mvc_msg_t     msg [2];
    int                    fail_count = 0;
    int                    check_count = 0;
    logic [31:0]           q, w;
    logic [5:0]            a6;

    always #25 core_clk = ~core_clk;

    for (genvar g = 0; g < 2; g++) begin : port_g
        mvc_cap_regs #(.IS_DOWNSTREAM(g == 1)) dut_u (.i_core_clk(core_clk), .i_rstn(rstn), .i_address(adr[g]),
            .i_read(rd[g]), .i_write(wr[g]), .i_writedata(wd[g]), .i_byteenable(4'hf), .o_readdata(rdat[g]),
            .o_waitrequest(wreq[g]), .o_rom(rom[g]), .i_rom_done(done[g]), .i_rom_rdata(rrd[g]),
            .i_svc_req(svc[g]), .i_msg_ready(rdy[g]), .o_msg(msg[g]), .o_intx(intx[g]), .o_irq(irq[g]));
        mvc_rom_model rom_u (.i_core_clk(core_clk), .i_rom(rom[g]), .o_rom_done(done[g]),
            .o_rom_rdata(rrd[g]), .o_msg_ready(rdy[g]));
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
            fail_count++;
        end
    endtask

    // one access, entered just after a rising edge; held until the rising edge that samples
    // waitrequest low, where read data is taken; one idle edge follows before the next request
    task automatic acc(input int p, input bit w_en, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        adr[p] <= a;
        wd[p]  <= d;
        wr[p]  <= w_en;
        rd[p]  <= !w_en;
        do begin
            @(posedge core_clk);
            n++;
        end while (wreq[p] !== 1'b0 && n < 40);
        q = rdat[p];
        if (n >= 40) begin
            $display("BAD t=%0t got=%h exp=%h", $time, 32'h0000_0001, 32'h0000_0000);
            fail_count++;
        end
        wr[p] <= 1'b0;
        rd[p] <= 1'b0;
        @(posedge core_clk);
    endtask

    // polls the operation flag of the upstream port until it shows v
    task automatic poll(input logic v);
        int n;
        n = 0;
        do begin
            acc(0, 0, 8'h5c, 32'h0000_0000);
            n++;
        end while (q[31] !== v && n < 50);
    endtask

    task automatic pulse(input int p);
        svc[p] <= 1'b1;
        @(posedge core_clk);
        svc[p] <= 1'b0;
        @(negedge core_clk);
    endtask

    // reset image of each place on each role; absent places read zero
    function automatic logic [31:0] rst_val(input int p, input logic [7:0] a);
        if (a == 8'h64)
            return 32'h0034_b009;
        if (p == 1 && a == 8'h4c)
            return 32'h0080_6405;
        if (p == 0 && a == 8'h5c)
            return 32'h0000_6403;
        return 32'h0000_0000;
    endfunction

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge core_clk);
        fail_count++;
        end_sim();
    end

    initial begin
        void'($urandom(32'he34c_47a7));
        repeat (20) @(posedge core_clk);
        rstn <= 1'b1;
        @(posedge core_clk);
        for (int p = 0; p < 2; p++) begin
            for (int k = 0; k < 8; k++) begin
                acc(p, 0, 8'h4c + 8'(k * 4), 32'h0000_0000);
                chk(q, rst_val(p, 8'h4c + 8'(k * 4)));
            end
        end
        $display("test reset images done");
        // address all ones first: the two low bits must still read zero
        for (int k = 0; k < 3; k++) begin
            vals[k] = (k == 0) ? 32'hffff_ffff : $urandom();
            acc(1, 1, 8'h50 + 8'(k * 4), vals[k]);
            acc(1, 0, 8'h50 + 8'(k * 4), 32'h0000_0000);
            chk(q, vals[k] & ((k == 0) ? 32'hffff_fffc : (k == 1) ? 32'hffff_ffff : 32'h0000_ffff));
        end
        w = $urandom() | 32'h0001_0000;
        acc(1, 1, 8'h4c, w);
        acc(1, 0, 8'h4c, 32'h0000_0000);
        chk(q, (w & 32'h0071_0000) | 32'h0080_6405);
        acc(1, 1, 8'h84, 32'h0000_0003);
        pulse(1);
        chk({31'h0, intx[1]}, 32'h0000_0000);
        for (int n = 0; n < 40 && !(msg[1].valid === 1'b1 && rdy[1] === 1'b1); n++)
            @(negedge core_clk);
        chk(msg[1].addr[63:32], vals[1]);
        chk(msg[1].addr[31:0], vals[0] & 32'hffff_fffc);
        chk({16'h0000, msg[1].data}, vals[2] & 32'h0000_ffff);
        repeat (2) @(negedge core_clk);
        chk({31'h0, irq[1]}, 32'h0000_0001);
        @(posedge core_clk);
        acc(1, 0, 8'h80, 32'h0000_0000);
        chk(q, 32'h0000_0002);
        acc(1, 1, 8'h4c, 32'h0000_0000);
        pulse(1);
        chk({31'h0, intx[1]}, 32'h0000_0001);
        chk({31'h0, irq[1]}, 32'h0000_0000);
        @(posedge core_clk);
        $display("test message capability done");
        acc(0, 1, 8'h84, 32'h0000_0001);
        for (int k = 0; k < 3; k++) begin
            a6 = (k == 0) ? 6'h3f : 6'($urandom());
            w  = $urandom();
            acc(0, 1, 8'h60, w);
            acc(0, 1, 8'h5c, {2'b11, 6'h00, a6, 18'h0_0000});
            poll(1'b0);
            chk(port_g[0].rom_u.mem[a6], w);
            acc(0, 1, 8'h60, ~w);
            acc(0, 1, 8'h5c, {2'b00, 6'h00, a6, 18'h0_0000});
            poll(1'b1);
            chk(q, {2'b10, 6'h00, a6, 2'b00, 16'h6403});
            acc(0, 0, 8'h60, 32'h0000_0000);
            chk(q, w);
        end
        chk({31'h0, irq[0]}, 32'h0000_0001);
        acc(0, 0, 8'h80, 32'h0000_0000);
        chk(q, 32'h0000_0001);
        $display("test product data done");
        end_sim();
    end
endmodule
